// File: bench/acs_top_tb.sv
// self-checking testbench of the converter clock, mux and scan configuration block
`timescale 1ns/1ps

module acs_top_tb;

  //////////////////////////////////////////////////////////////////////////////
  // signals and design instance
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_strobe_in = 1'b0;
  logic rd_strobe_in = 1'b0;
  logic rc_tick_in = 1'b0;
  logic sample_start_in = 1'b0;
  logic sample_end_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic [15:0] rd_data_out;
  logic conv_clk_tick_out;
  logic conv_clk_source_rc_out;
  logic sampling_out;
  logic start_conv_out;
  logic mux_second_out;
  logic [4:0] pos_input_sel_out;
  logic neg_input_ain1_out;
  logic [2:0] bandgap_en_out;
  logic [15:0] small_rd_data;
  logic [4:0] small_pos_sel;
  int errors = 0;
  int check_count = 0;

  acs_top u_acs_top (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
    .rd_data_out(rd_data_out), .rc_tick_in(rc_tick_in), .sample_start_in(sample_start_in),
    .sample_end_in(sample_end_in), .conv_done_in(conv_done_in),
    .conv_clk_tick_out(conv_clk_tick_out), .conv_clk_source_rc_out(conv_clk_source_rc_out),
    .sampling_out(sampling_out), .start_conv_out(start_conv_out),
    .mux_second_out(mux_second_out), .pos_input_sel_out(pos_input_sel_out),
    .neg_input_ain1_out(neg_input_ain1_out), .bandgap_en_out(bandgap_en_out)
  );

  // small package variant on the same stimulus
  acs_top #(
    .SMALL_PKG(1'b1)
  ) u_acs_top_small (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
    .rd_data_out(small_rd_data), .rc_tick_in(rc_tick_in), .sample_start_in(sample_start_in),
    .sample_end_in(sample_end_in), .conv_done_in(conv_done_in), .conv_clk_tick_out(),
    .conv_clk_source_rc_out(), .sampling_out(), .start_conv_out(), .mux_second_out(),
    .pos_input_sel_out(small_pos_sel), .neg_input_ain1_out(), .bandgap_en_out()
  );

  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;

  //////////////////////////////////////////////////////////////////////////////
  // compare, bus and sequence tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_strobe_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_strobe_in <= 1'b0;
  endtask

  // one-cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_strobe_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_strobe_in <= 1'b0;
    #1;
    chk("read data", exp, rd_data_out);
  endtask

  // counts conversion ticks over 40 cycles, rc ticks every per cycles
  task automatic count_ticks(input int per, input int exp);
    int n;
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk_in);
      rc_tick_in <= (per != 0) && (i % per == 0);
      #1;
      n += int'(conv_clk_tick_out === 1'b1);
    end
    chk("tick count", 16'(exp), 16'(n));
  endtask

  // one sample and convert pass, sampling length measured in cycles
  task automatic run_conv(input bit man, input int exp_n);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    sample_start_in <= 1'b1;
    for (int k = 0; k < 100; k++)
    begin
      @(posedge ref_clk_in);
      sample_start_in <= 1'b0;
      sample_end_in <= man && (n == 2);
      #1;
      if (start_conv_out === 1'b1)
        break;
      n += int'(sampling_out === 1'b1);
    end
    chk("sample cycles", 16'(exp_n), 16'(n));
    @(posedge ref_clk_in);
    sample_end_in <= 1'b0;
    conv_done_in <= 1'b1;
    #1;
    chk("start pulse width", 16'h0000, 16'(start_conv_out));
    @(posedge ref_clk_in);
    conv_done_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial
  begin
    #300000;
    errors++;
    test_done;
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [15:0] wexp [5];
    logic [4:0] codes [10];
    logic [4:0] cexp [10];
    logic [4:0] sexp [10];
    logic [4:0] alt_pos [4];
    wexp = '{16'h9fff, 16'h9f9f, 16'h0007, 16'hffff, 16'h0fff};
    codes = '{5'h00, 5'h01, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1f, 5'h10, 5'h0f};
    cexp = '{5'h00, 5'h01, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1f, 5'h10, 5'h0f};
    sexp = '{5'h00, 5'h01, 5'h1f, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1f, 5'h1f, 5'h0f};
    alt_pos = '{5'h09, 5'h05, 5'h09, 5'h02};
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    // reset values and unmapped reads
    for (int a = 0; a < 6; a++)
      rd(4'(a), 16'h0000);
    rd(4'h7, 16'h0000);
    rd(4'hf, 16'h0000);
    rd(4'h6, 16'h001f);
    // writable bits of registers 0 to 4, then a write to unmapped address 7
    for (int a = 0; a < 5; a++)
    begin
      wr(4'(a), (a == 0) ? 16'h9fff : 16'hffff);
      rd(4'(a), wexp[a]);
      if (a == 4)
        chk("small high mask", 16'h0f00, small_rd_data);
    end
    wr(4'h7, 16'hffff);
    rd(4'h7, 16'h0000);
    rd(4'h2, 16'h0007);
    @(posedge ref_clk_in);
    #1;
    chk("rd data after one cycle", 16'h0000, rd_data_out);
    chk("band gap enables", 16'h0007, 16'(bandgap_en_out));
    chk("rc source", 16'h0001, 16'(conv_clk_source_rc_out));
    wr(4'h2, 16'h0002);
    rd(4'h2, 16'h0002);
    chk("band gap half only", 16'h0002, 16'(bandgap_en_out));
    // conversion clock divider and source
    wr(4'h0, 16'h0003);
    count_ticks(0, 10);
    wr(4'h0, 16'h0000);
    count_ticks(0, 40);
    wr(4'h0, 16'h8000);
    count_ticks(4, 10);
    chk("rc source", 16'h0001, 16'(conv_clk_source_rc_out));
    // positive code decode of the first setting, scan off
    wr(4'h0, 16'h0000);
    wr(4'h3, 16'h0000);
    wr(4'h4, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      wr(4'h1, {8'h00, 3'b100, codes[i]});
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("first positive", 16'(cexp[i]), 16'(pos_input_sel_out));
      chk("small positive", 16'(sexp[i]), 16'(small_pos_sel));
      chk("first negative", 16'h0001, 16'(neg_input_ain1_out));
    end
    // auto-sample length in conversion periods, divider 0
    wr(4'h5, 16'h00e0);
    run_conv(1'b0, 1);
    wr(4'h0, 16'h0300);
    run_conv(1'b0, 4);
    wr(4'h0, 16'h1f00);
    run_conv(1'b0, 32);
    // sampling ended by the external event
    wr(4'h5, 16'h0000);
    run_conv(1'b1, 3);
    // alternate settings with scanning of channels 2 and 5
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h8900);
    wr(4'h3, 16'h0024);
    wr(4'h5, 16'h04e1);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("scan start", 16'h0002, 16'(pos_input_sel_out));
    chk("first setting", 16'h0000, 16'(mux_second_out));
    chk("negative reference", 16'h0000, 16'(neg_input_ain1_out));
    for (int i = 0; i < 4; i++)
    begin
      run_conv(1'b0, 1);
      chk("setting in use", 16'(i % 2 == 0), 16'(mux_second_out));
      chk("scan positive", 16'(alt_pos[i]), 16'(pos_input_sel_out));
      chk("alt negative", 16'(i % 2 == 0), 16'(neg_input_ain1_out));
    end
    test_done;
  end

endmodule

// File: hw/acs_scan_step.sv
// next selected scan channel after a given one, wrapping to the lowest
`timescale 1ns/1ps

module acs_scan_step #(
  parameter int BITS = 28
) (
  // scan mask and current channel
  input wire logic [BITS-1:0] mask_in,
  input wire logic [4:0] from_in,
  // next channel, float code when mask is empty
  output logic [4:0] next_out
);

  generate
    if (BITS < 1 || BITS > 31)
    begin : g_chk
      $error("scan mask width out of range");
    end
  endgenerate

  logic [4:0] above;
  logic [4:0] lowest;
  logic hit_above;
  logic hit_any;

  // descending walk keeps the smallest match
  always_comb
  begin
    above = 5'h1f;
    lowest = 5'h1f;
    hit_above = 1'b0;
    hit_any = 1'b0;
    for (int i = BITS - 1; i >= 0; i--)
    begin
      if (mask_in[i])
      begin
        lowest = 5'(i);
        hit_any = 1'b1;
        if (5'(i) > from_in)
        begin
          above = 5'(i);
          hit_above = 1'b1;
        end
      end
    end
    next_out = hit_above ? above : (hit_any ? lowest : 5'h1f);
  end

endmodule

// File: hw/acs_tad_gen.sv
// conversion clock period tick generator
`timescale 1ns/1ps

module acs_tad_gen #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic rc_sel_in,
  input wire logic [DIV_W-1:0] div_in,
  // rc oscillator tick
  input wire logic rc_tick_in,
  // one pulse per conversion clock period
  output logic tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } acs_tad_state_t;

  acs_tad_state_t s;
  acs_tad_state_t next_s;

  generate
    if (DIV_W < 1 || DIV_W > 16)
    begin : g_chk
      $error("divider width out of range");
    end
  endgenerate

  // period source and divider count
  always_comb
  begin
    next_s = s;
    if (rc_sel_in)
    begin
      next_s.tick = rc_tick_in;
      next_s.cnt = '0;
    end
    // period of div plus one cycles; a shrunk divider ends the period at once
    else if (s.cnt >= div_in)
    begin
      next_s.tick = 1'b1;
      next_s.cnt = '0;
    end
    else
    begin
      next_s.tick = 1'b0;
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick_out = s.tick;

  // cycles since the last tick, for the period check
  logic [DIV_W:0] gap;
  logic cfg_moved;
  logic [DIV_W-1:0] div_prev;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap <= '0;
      cfg_moved <= 1'b1;
      div_prev <= '0;
    end
    else
    begin
      div_prev <= div_in;
      if (s.tick)
      begin
        gap <= '0;
        cfg_moved <= rc_sel_in | (div_in != div_prev);
      end
      else
      begin
        gap <= gap + 1'b1;
        cfg_moved <= cfg_moved | rc_sel_in | (div_in != div_prev);
      end
    end
  end

  rc_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rc_sel_in |=> tick_out == $past(rc_tick_in))
    else $error("rc tick not passed through");

  div_period_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (s.tick && !rc_sel_in && !cfg_moved && $stable(div_in)) |-> gap == {1'b0, div_in})
    else $error("conversion clock period wrong");

endmodule

// File: hw/acs_top.sv
// converter clock, input mux and scan configuration with sample sequencer
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Function
// - rc bit picks rc clock, else system
// - 5-bit auto-sample time in conversion periods
// - conversion period equals divider plus one
// - second setting negative input ain1 or reference
// - second setting positive code decode
// - first setting negative input ain1 or reference
// - first setting positive code, same decode
// - small package lacks inputs 16-23
// - three band gap enables, upper bits zero
// - low scan mask covers channels 0-15
// - high low byte channels 16-23, small zero
// - high bits 8-11 internal taps, 15-12 zero
// - mux bits 6-5 read zero, ignore writes
// - scan enable scans first setting positive input
// - alternate mode toggles settings after each sample
// - auto trigger ends sampling by counter
module acs_top #(
  parameter bit SMALL_PKG = 1'b0,
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [15:0] rd_data_out,
  // converter events
  input wire logic rc_tick_in,
  input wire logic sample_start_in,
  input wire logic sample_end_in,
  input wire logic conv_done_in,
  // converter controls
  output logic conv_clk_tick_out,
  output logic conv_clk_source_rc_out,
  output logic sampling_out,
  output logic start_conv_out,
  output logic mux_second_out,
  output logic [4:0] pos_input_sel_out,
  output logic neg_input_ain1_out,
  output logic [2:0] bandgap_en_out
);

  generate
    if (DIV_W != 8)
    begin : g_chk
      $error("divider field is eight bits");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] timing;
    logic [15:0] mux;
    logic [2:0] bg;
    logic [15:0] scan_lo;
    logic [11:0] scan_hi;
    logic scan_en;
    logic [2:0] trig;
    logic alt;
    acs_pkg::acs_seq_t seq;
    logic sampling;
    logic [4:0] samp_cnt;
    logic use_second;
    logic [4:0] scan_ptr;
    logic start_conv;
    logic [4:0] pos_out;
    logic neg_out;
    logic [15:0] rdata;
  } acs_state_t;

  acs_state_t s;
  acs_state_t next_s;

  //////////////////////////////////////////////////////////////////////////
  // field views
  logic conv_clk_source_rc;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clk_divider;
  logic neg_input_sel_second;
  logic [4:0] pos_input_sel_second;
  logic neg_input_sel_first;
  logic [4:0] pos_input_sel_first;
  logic [27:0] scan_channel_mask;
  logic [15:0] scan_hi_wmask;
  logic tad_tick;
  logic [4:0] scan_from;
  logic [4:0] scan_next;

  assign conv_clk_source_rc = s.timing[acs_pkg::CLK_RC_BIT];
  assign auto_sample_time = s.timing[acs_pkg::SAMP_LSB +: 5];
  assign conv_clk_divider = s.timing[acs_pkg::DIV_LSB +: 8];
  assign neg_input_sel_second = s.mux[acs_pkg::NEG2_BIT];
  assign pos_input_sel_second = s.mux[acs_pkg::POS2_LSB +: 5];
  assign neg_input_sel_first = s.mux[acs_pkg::NEG1_BIT];
  assign pos_input_sel_first = s.mux[acs_pkg::POS1_LSB +: 5];
  // scan mask bit index equals positive input code
  assign scan_channel_mask = {s.scan_hi, s.scan_lo};
  // high channels absent on small package
  assign scan_hi_wmask = SMALL_PKG ? acs_pkg::SCAN_HI_SMALL_WMASK : acs_pkg::SCAN_HI_WMASK;
  // search from the top when scanning is off, so the pointer rests on the lowest
  assign scan_from = s.scan_en ? s.scan_ptr : acs_pkg::CODE_FLOAT;

  //////////////////////////////////////////////////////////////////////////
  // conversion clock ticks
  acs_tad_gen #(
    .DIV_W(DIV_W)
  ) u_tad (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .rc_sel_in(conv_clk_source_rc),
    .div_in(conv_clk_divider),
    .rc_tick_in(rc_tick_in),
    .tick_out(tad_tick)
  );

  // next scan channel
  acs_scan_step #(
    .BITS(acs_pkg::SCAN_BITS)
  ) u_step (
    .mask_in(scan_channel_mask),
    .from_in(scan_from),
    .next_out(scan_next)
  );

  //////////////////////////////////////////////////////////////////////////
  // legal positive codes, others float the input
  function automatic logic [4:0] acs_legal_code(input logic [4:0] code);
    logic [4:0] last_an;
    last_an = SMALL_PKG ? acs_pkg::CODE_SMALL_LAST_AN : acs_pkg::CODE_LAST_AN;
    if (code <= last_an)
      acs_legal_code = code;
    else if (code >= acs_pkg::CODE_BG_HALF && code <= acs_pkg::CODE_BG_SIXTH)
      acs_legal_code = code;
    else
      acs_legal_code = acs_pkg::CODE_FLOAT;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register writes, sequencer, mux selection, read data
  always_comb
  begin
    next_s = s;
    next_s.start_conv = 1'b0;
    next_s.rdata = 16'h0000;
    // register writes
    if (wr_strobe_in)
    begin
      case (addr_in)
        acs_pkg::ADDR_TIMING:
          next_s.timing = wr_data_in & acs_pkg::TIMING_WMASK;
        acs_pkg::ADDR_MUX:
          next_s.mux = wr_data_in & acs_pkg::MUX_WMASK;
        acs_pkg::ADDR_BG:
          next_s.bg = wr_data_in[2:0] & acs_pkg::BG_WMASK[2:0];
        acs_pkg::ADDR_SCAN_LO:
          next_s.scan_lo = wr_data_in;
        acs_pkg::ADDR_SCAN_HI:
          next_s.scan_hi = wr_data_in[11:0] & scan_hi_wmask[11:0];
        acs_pkg::ADDR_SEQ:
        begin
          next_s.scan_en = wr_data_in[acs_pkg::SCAN_EN_BIT];
          next_s.trig = wr_data_in[acs_pkg::TRIG_LSB +: 3];
          next_s.alt = wr_data_in[acs_pkg::ALT_BIT];
        end
        default:
          next_s.mux = s.mux;
      endcase
    end
    // sample and convert sequence
    case (s.seq)
      acs_pkg::ACS_IDLE:
      begin
        if (sample_start_in)
        begin
          next_s.seq = acs_pkg::ACS_SAMPLE;
          next_s.samp_cnt = 5'h00;
        end
      end
      acs_pkg::ACS_SAMPLE:
      begin
        // counter ends sampling, then conversion starts
        if (s.trig == acs_pkg::TRIG_AUTO)
        begin
          if (s.samp_cnt == auto_sample_time)
          begin
            next_s.start_conv = 1'b1;
            next_s.seq = acs_pkg::ACS_CONVERT;
          end
          else if (tad_tick)
            next_s.samp_cnt = s.samp_cnt + 5'h01;
        end
        else if (sample_end_in)
        begin
          next_s.start_conv = 1'b1;
          next_s.seq = acs_pkg::ACS_CONVERT;
        end
      end
      acs_pkg::ACS_CONVERT:
      begin
        if (conv_done_in)
        begin
          next_s.seq = acs_pkg::ACS_IDLE;
          next_s.use_second = s.alt & ~s.use_second;
          // step to next selected channel after a first-setting sample
          if (!s.use_second)
            next_s.scan_ptr = scan_next;
        end
      end
      default:
        next_s.seq = acs_pkg::ACS_IDLE;
    endcase
    // sampling level registered beside the state
    next_s.sampling = (next_s.seq == acs_pkg::ACS_SAMPLE);
    // without alternate mode the first setting stays
    if (!s.alt)
      next_s.use_second = 1'b0;
    // scanning off parks the pointer on the lowest channel
    if (!s.scan_en)
      next_s.scan_ptr = scan_next;
    // input selection for the sample to come
    if (next_s.use_second)
    begin
      next_s.pos_out = acs_legal_code(pos_input_sel_second);
      next_s.neg_out = neg_input_sel_second;
    end
    else
    begin
      // scan pointer replaces first positive field; via decode
      next_s.pos_out = acs_legal_code(s.scan_en ? s.scan_ptr : pos_input_sel_first);
      next_s.neg_out = neg_input_sel_first;
    end
    // read data, standing one cycle after the strobe
    if (rd_strobe_in)
    begin
      case (addr_in)
        acs_pkg::ADDR_TIMING: next_s.rdata = s.timing;
        acs_pkg::ADDR_MUX: next_s.rdata = s.mux;
        acs_pkg::ADDR_BG: next_s.rdata = {13'h0, s.bg};
        acs_pkg::ADDR_SCAN_LO: next_s.rdata = s.scan_lo;
        acs_pkg::ADDR_SCAN_HI: next_s.rdata = {4'h0, s.scan_hi};
        acs_pkg::ADDR_SEQ:
          next_s.rdata = {5'h00, s.scan_en, 2'h0, s.trig, 4'h0, s.alt};
        acs_pkg::ADDR_STAT:
          next_s.rdata = {8'h00, s.seq == acs_pkg::ACS_CONVERT,
            s.seq == acs_pkg::ACS_SAMPLE, s.use_second, s.scan_ptr};
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s <= '0;
      s.timing <= acs_pkg::REG_RESET;
      s.mux <= acs_pkg::REG_RESET;
      s.seq <= acs_pkg::ACS_IDLE;
    end
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign rd_data_out = s.rdata;
  assign conv_clk_tick_out = tad_tick;
  assign conv_clk_source_rc_out = conv_clk_source_rc;
  assign sampling_out = s.sampling;
  assign start_conv_out = s.start_conv;
  assign mux_second_out = s.use_second;
  assign pos_input_sel_out = s.pos_out;
  assign neg_input_ain1_out = s.neg_out;
  assign bandgap_en_out = s.bg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence rd_of_s(logic [3:0] a);
    rd_strobe_in && addr_in == a;
  endsequence

  sequence auto_end_s;
    s.seq == acs_pkg::ACS_SAMPLE && s.trig == acs_pkg::TRIG_AUTO
      && s.samp_cnt == auto_sample_time;
  endsequence

  sequence conv_start_s;
    start_conv_out && !sampling_out ##1 !start_conv_out;
  endsequence

  bg_upper_zero_a: assert property (rd_of_s(acs_pkg::ADDR_BG) |=>
    rd_data_out[15:3] == 13'h0000 && rd_data_out[2:0] == $past(s.bg))
    else $error("band gap register read wrong");

  mux_unimpl_a: assert property (rd_of_s(acs_pkg::ADDR_MUX) |=>
    rd_data_out[6:5] == 2'h0 && rd_data_out[14:13] == 2'h0)
    else $error("mux unimplemented bits not zero");

  scan_hi_top_a: assert property (rd_of_s(acs_pkg::ADDR_SCAN_HI) |=>
    rd_data_out[15:12] == 4'h0)
    else $error("scan high upper bits not zero");

  small_hi_zero_a: assert property ((rd_of_s(acs_pkg::ADDR_SCAN_HI) and SMALL_PKG) |=>
    rd_data_out[7:0] == 8'h00)
    else $error("small package high channels readable");

  small_pos_a: assert property (!(SMALL_PKG && pos_input_sel_out > 5'h0f
    && pos_input_sel_out <= 5'h17))
    else $error("missing input selected");

  auto_end_a: assert property (auto_end_s |=> conv_start_s)
    else $error("auto sample end did not start conversion");

  early_end_a: assert property ((s.seq == acs_pkg::ACS_SAMPLE
    && s.trig == acs_pkg::TRIG_AUTO && s.samp_cnt != auto_sample_time) |=> !start_conv_out)
    else $error("sampling ended early");

  alt_off_a: assert property (!s.alt |=> !mux_second_out)
    else $error("second setting used without alternate mode");

  alt_toggle_a: assert property ((s.alt && $past(s.alt) && conv_done_in
    && s.seq == acs_pkg::ACS_CONVERT) |=> mux_second_out != $past(mux_second_out))
    else $error("settings did not alternate");

  scan_pick_a: assert property ((s.scan_en && !s.use_second && !next_s.use_second
    && scan_channel_mask[s.scan_ptr]) |=> pos_input_sel_out == $past(s.scan_ptr))
    else $error("scan channel not selected");

  scan_wrap_a: assert property ((s.scan_en && conv_done_in && !s.use_second
    && s.seq == acs_pkg::ACS_CONVERT && scan_channel_mask != 28'h0000000)
    |=> scan_channel_mask[s.scan_ptr] && ((s.scan_ptr > $past(s.scan_ptr))
    || ((scan_channel_mask >> $past(s.scan_ptr)) <= 28'h0000001
    && (scan_channel_mask & ((28'h0000001 << s.scan_ptr) - 28'h0000001)) == 28'h0000000)))
    else $error("scan step not ascending");

endmodule

// File: shared/acs_pkg.sv
// shared constants and types of the converter clock, mux and scan configuration block
package acs_pkg;

  // register bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register addresses on the plain port
  localparam logic [3:0] ADDR_TIMING = 4'h0;
  localparam logic [3:0] ADDR_MUX = 4'h1;
  localparam logic [3:0] ADDR_BG = 4'h2;
  localparam logic [3:0] ADDR_SCAN_LO = 4'h3;
  localparam logic [3:0] ADDR_SCAN_HI = 4'h4;
  localparam logic [3:0] ADDR_SEQ = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;

  // field positions, conv_clock_timing_ctrl
  localparam int CLK_RC_BIT = 15;
  localparam int SAMP_LSB = 8;
  localparam int DIV_LSB = 0;
  // field positions, input_mux_select
  localparam int NEG2_BIT = 15;
  localparam int POS2_LSB = 8;
  localparam int NEG1_BIT = 7;
  localparam int POS1_LSB = 0;
  // field positions, sequence control
  localparam int SCAN_EN_BIT = 10;
  localparam int TRIG_LSB = 5;
  localparam int ALT_BIT = 0;

  // writable bits of each register
  localparam logic [15:0] TIMING_WMASK = 16'hffff;
  localparam logic [15:0] MUX_WMASK = 16'h9f9f;
  localparam logic [15:0] BG_WMASK = 16'h0007;
  localparam logic [15:0] SCAN_HI_WMASK = 16'h0fff;
  localparam logic [15:0] SCAN_HI_SMALL_WMASK = 16'h0f00;
  localparam logic [15:0] SEQ_WMASK = 16'h04e1;

  // values after reset
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // positive input codes
  localparam logic [4:0] CODE_LAST_AN = 5'h17;
  localparam logic [4:0] CODE_SMALL_LAST_AN = 5'h0f;
  localparam logic [4:0] CODE_BG_HALF = 5'h18;
  localparam logic [4:0] CODE_BG_SIXTH = 5'h1b;
  localparam logic [4:0] CODE_FLOAT = 5'h1f;
  localparam int SCAN_BITS = 28;

  // trigger source that ends sampling by the internal counter
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  // sample and convert sequence
  typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_seq_t;

endpackage
